// ===== shared/amwd_regs.vh
`ifndef AMWD_REGS_VH
`define AMWD_REGS_VH

// register indices; byte address is four times the index
`define AMWD_IDX_NP_BASE 8'h20
`define AMWD_IDX_NP_LIMIT 8'h22
`define AMWD_IDX_PF_BASE 8'h24
`define AMWD_IDX_PF_LIMIT 8'h26
`define AMWD_IDX_BCTRL 8'h3e
// own register: host cycle classifier, written address, read result
`define AMWD_IDX_PROBE_ADDR 8'h40
`define AMWD_IDX_PROBE_RES 8'h41

`define AMWD_BASE_RESET 16'hfff0
`define AMWD_LIMIT_RESET 16'h0000
`define AMWD_BCTRL_RESET 8'h00
`define AMWD_FIELD_LSB 4
`define AMWD_FIELD_W 12

`define AMWD_RESP_OKAY 2'b00
`define AMWD_RESP_SLVERR 2'b10

`endif

// ===== hdl/amwd_window.v
`timescale 1ns/10ps
// one memory window: inclusive compare against 1-MB granular bounds
module amwd_window #(
   parameter FW = 12
) (
   // window fields, address bits 31:20
   input wire [FW-1:0] base_field,
   input wire [FW-1:0] limit_field,
   // host address
   input wire [31:0] addr,
   // result
   output wire hit
);
   wire [31:0] lo;
   wire [31:0] hi;

   assign lo = {base_field, {(32-FW){1'b0}}};
   assign hi = {limit_field, {(32-FW){1'b1}}};
   // base above limit gives an empty window with no special case
   assign hit = (addr >= lo) && (addr <= hi);
endmodule

// ===== hdl/amwd_top.v
`timescale 1ns/10ps
`include "amwd_regs.vh"
// What this block does
// - forward non-prefetchable window hits, bounds inclusive
// - forward prefetchable window hits, bounds inclusive
// - upper twelve bits hold address 31:20
// - low four bits read zero, ignore writes
// - base compare treats bits 19:0 as zero
// - limit compare treats bits 19:0 as ones
// - base registers reset to fff0
// - limit registers reset to zero
// - bridge control register, 8 bits, resets 00
module amwd_top (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [31:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [31:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // host memory cycle decode
   input wire [31:0] host_addr,
   input wire host_valid,
   output wire agp_np_fwd,
   output wire agp_pf_fwd,
   // bridge control contents
   output wire [7:0] bridge_ctrl
);
   localparam FW = `AMWD_FIELD_W;
   localparam LSB = `AMWD_FIELD_LSB;
   // reset images cut to the stored field; the low nibble is never kept
   localparam [15:0] BASE_RST = `AMWD_BASE_RESET;
   localparam [15:0] LIMIT_RST = `AMWD_LIMIT_RESET;
   localparam [FW-1:0] BASE_FIELD_RST = BASE_RST[15:LSB];
   localparam [FW-1:0] LIMIT_FIELD_RST = LIMIT_RST[15:LSB];

   // software-visible fields
   reg [FW-1:0] np_base_field_q;
   reg [FW-1:0] np_limit_field_q;
   reg [FW-1:0] pf_base_field_q;
   reg [FW-1:0] pf_limit_field_q;
   reg [7:0] bctrl_q;
   reg [31:0] probe_addr_q;
   reg np_fwd_q;
   reg pf_fwd_q;
   // next values of the registers above
   reg [FW-1:0] np_base_field_d;
   reg [FW-1:0] np_limit_field_d;
   reg [FW-1:0] pf_base_field_d;
   reg [FW-1:0] pf_limit_field_d;
   reg [7:0] bctrl_d;
   reg [31:0] probe_addr_d;
   wire np_fwd_d;
   wire pf_fwd_d;

   // bus channel state
   reg aw_full_q;
   reg [31:0] aw_addr_q;
   reg w_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;

   // window compare results
   wire np_hit;
   wire pf_hit;
   wire pr_np_hit;
   wire pr_pf_hit;
   wire do_write;
   wire do_read;
   wire [7:0] w_idx;
   wire [7:0] r_idx;

   // word index from byte address, bits 1:0 ignored, addresses above 3ff give ff
   function [7:0] word_idx;
      input [31:0] a;
      begin
         if (a[31:10] != 22'h000000)
            word_idx = 8'hff;
         else
            word_idx = a[9:2];
      end
   endfunction

   function is_mapped;
      input [7:0] idx;
      begin
         case (idx)
            `AMWD_IDX_NP_BASE, `AMWD_IDX_NP_LIMIT,
            `AMWD_IDX_PF_BASE, `AMWD_IDX_PF_LIMIT,
            `AMWD_IDX_BCTRL, `AMWD_IDX_PROBE_ADDR,
            `AMWD_IDX_PROBE_RES: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // merge a 16-bit window register write; low nibble is dropped
   function [FW-1:0] merge16;
      input [FW-1:0] old;
      input [31:0] d;
      input [3:0] s;
      reg [15:0] v;
      begin
         v = {old, 4'h0};
         if (s[0])
            v[7:0] = d[7:0];
         if (s[1])
            v[15:8] = d[15:8];
         merge16 = v[15:LSB];
      end
   endfunction

   // merge a full word under its byte strobes
   function [31:0] merge32;
      input [31:0] old;
      input [31:0] d;
      input [3:0] s;
      integer k;
      begin
         merge32 = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (s[k])
               merge32[8*k +: 8] = d[8*k +: 8];
         end
      end
   endfunction

   // a window register as software sees it: low nibble reads zero
   function [31:0] field_word;
      input [FW-1:0] f;
      begin
         field_word = {16'h0000, f, 4'h0};
      end
   endfunction

   // host address against both windows
   amwd_window #(.FW(FW)) u_np (
      .base_field(np_base_field_q),
      .limit_field(np_limit_field_q),
      .addr(host_addr),
      .hit(np_hit)
   );

   amwd_window #(.FW(FW)) u_pf (
      .base_field(pf_base_field_q),
      .limit_field(pf_limit_field_q),
      .addr(host_addr),
      .hit(pf_hit)
   );

   // probe address against the same windows
   amwd_window #(.FW(FW)) u_np_probe (
      .base_field(np_base_field_q),
      .limit_field(np_limit_field_q),
      .addr(probe_addr_q),
      .hit(pr_np_hit)
   );

   amwd_window #(.FW(FW)) u_pf_probe (
      .base_field(pf_base_field_q),
      .limit_field(pf_limit_field_q),
      .addr(probe_addr_q),
      .hit(pr_pf_hit)
   );

   // registered decode: one cycle after the host address is presented
   assign np_fwd_d = host_valid & np_hit;
   assign pf_fwd_d = host_valid & pf_hit;

   always @(posedge aclk) begin
      if (!aresetn) begin
         np_fwd_q <= 1'b0;
         pf_fwd_q <= 1'b0;
      end else begin
         np_fwd_q <= np_fwd_d;
         pf_fwd_q <= pf_fwd_d;
      end
   end

   assign agp_np_fwd = np_fwd_q;
   assign agp_pf_fwd = pf_fwd_q;
   assign bridge_ctrl = bctrl_q;

   // write channel: address and data accepted in any order, held here
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready = !w_full_q && !bvalid_q;
   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign w_idx = word_idx(aw_addr_q);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 32'h00000000;
         w_full_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `AMWD_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(w_idx) ? `AMWD_RESP_OKAY
                                         : `AMWD_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // next register values; a write lands once both halves are held
   always @* begin
      np_base_field_d = np_base_field_q;
      np_limit_field_d = np_limit_field_q;
      pf_base_field_d = pf_base_field_q;
      pf_limit_field_d = pf_limit_field_q;
      bctrl_d = bctrl_q;
      probe_addr_d = probe_addr_q;
      if (do_write) begin
         case (w_idx)
            `AMWD_IDX_NP_BASE:
               np_base_field_d = merge16(np_base_field_q, w_data_q,
                                         w_strb_q);
            `AMWD_IDX_NP_LIMIT:
               np_limit_field_d = merge16(np_limit_field_q, w_data_q,
                                          w_strb_q);
            `AMWD_IDX_PF_BASE:
               pf_base_field_d = merge16(pf_base_field_q, w_data_q,
                                         w_strb_q);
            `AMWD_IDX_PF_LIMIT:
               pf_limit_field_d = merge16(pf_limit_field_q, w_data_q,
                                          w_strb_q);
            `AMWD_IDX_BCTRL: begin
               if (w_strb_q[0])
                  bctrl_d = w_data_q[7:0];
            end
            `AMWD_IDX_PROBE_ADDR:
               probe_addr_d = merge32(probe_addr_q, w_data_q, w_strb_q);
            default: begin
            end
         endcase
      end
   end

   // register storage; windows stay empty until software loads them
   always @(posedge aclk) begin
      if (!aresetn) begin
         np_base_field_q <= BASE_FIELD_RST;
         pf_base_field_q <= BASE_FIELD_RST;
         np_limit_field_q <= LIMIT_FIELD_RST;
         pf_limit_field_q <= LIMIT_FIELD_RST;
         bctrl_q <= `AMWD_BCTRL_RESET;
         probe_addr_q <= 32'h00000000;
      end else begin
         np_base_field_q <= np_base_field_d;
         np_limit_field_q <= np_limit_field_d;
         pf_base_field_q <= pf_base_field_d;
         pf_limit_field_q <= pf_limit_field_d;
         bctrl_q <= bctrl_d;
         probe_addr_q <= probe_addr_d;
      end
   end

   // read channel: one cycle from address accept to data
   assign s_axi_arready = !rvalid_q;
   assign do_read = s_axi_arvalid && !rvalid_q;
   assign r_idx = word_idx(s_axi_araddr);

   // read data for the addressed register
   always @* begin
      case (r_idx)
         `AMWD_IDX_NP_BASE:
            rdata_d = field_word(np_base_field_q);
         `AMWD_IDX_NP_LIMIT:
            rdata_d = field_word(np_limit_field_q);
         `AMWD_IDX_PF_BASE:
            rdata_d = field_word(pf_base_field_q);
         `AMWD_IDX_PF_LIMIT:
            rdata_d = field_word(pf_limit_field_q);
         `AMWD_IDX_BCTRL:
            rdata_d = {24'h000000, bctrl_q};
         `AMWD_IDX_PROBE_ADDR:
            rdata_d = probe_addr_q;
         // lets software check a window setting without host traffic
         `AMWD_IDX_PROBE_RES:
            rdata_d = {30'h00000000, pr_pf_hit, pr_np_hit};
         default:
            rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `AMWD_RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(r_idx) ? `AMWD_RESP_OKAY
                                      : `AMWD_RESP_SLVERR;
         rdata_q <= rdata_d;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
endmodule

// ===== tb/amwd_top_chk.sv
`timescale 1ns/10ps
module amwd_top_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // write channels
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // read channels
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // host decode
   input wire host_valid,
   input wire agp_np_fwd,
   input wire agp_pf_fwd
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   b_after_wr_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   b_drop_a: assert property ($past(aresetn) && $fell(s_axi_bvalid)
      |-> $past(s_axi_bready)) else $error("bvalid dropped unaccepted");
   w_block_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
   r_after_rd_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data missing");
   r_drop_a: assert property ($past(aresetn) && $fell(s_axi_rvalid)
      |-> $past(s_axi_rready)) else $error("rvalid dropped unaccepted");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read not held off");
   np_cause_a: assert property (
      agp_np_fwd |-> $past(host_valid)) else $error("np forward uncaused");
   pf_cause_a: assert property (
      agp_pf_fwd |-> $past(host_valid)) else $error("pf forward uncaused");
endmodule

bind amwd_top amwd_top_chk amwd_top_chk_i (.*);

// ===== tb/amwd_agp_model.sv
`timescale 1ns/10ps
// graphics target: counts the cycles claimed through each window
module amwd_agp_model (
   // clock
   input wire aclk,
   // forwarded cycles
   input wire np_fwd,
   input wire pf_fwd,
   // claimed totals
   output integer np_seen,
   output integer pf_seen
);
   initial np_seen = 0;
   initial pf_seen = 0;
   always @(posedge aclk) begin
      if (np_fwd === 1'b1) np_seen <= np_seen + 1;
      if (pf_fwd === 1'b1) pf_seen <= pf_seen + 1;
   end
endmodule

// ===== tb/test_agp_memory_window_decode.sv
`timescale 1ns/10ps
module test_agp_memory_window_decode;
   reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   reg s_axi_arvalid, s_axi_rready, host_valid;
   reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, host_addr;
   reg [2:0] s_axi_awprot, s_axi_arprot;
   reg [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, agp_np_fwd, agp_pf_fwd;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] bridge_ctrl;
   integer mismatches, checked, np_seen, pf_seen;
   amwd_top amwd_top_i (.*);
   amwd_agp_model amwd_agp_model_i (.aclk(aclk), .np_fwd(agp_np_fwd),
      .pf_fwd(agp_pf_fwd), .np_seen(np_seen), .pf_seen(pf_seen));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task report_and_stop;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task hang;
      begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   endtask
   // a bus wait that never ends is cut off after 50 cycles
   task wr(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      integer n;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (n = 0; n < 50; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
               s_axi_bready <= 1'b0;
               chk("bresp", er, s_axi_bresp);
               n = 99;
            end
         end
         if (n != 100) hang;
      end
   endtask
   task rd(input [31:0] a, input [31:0] ed, input [1:0] er);
      integer n;
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (n = 0; n < 50; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
               s_axi_rready <= 1'b0;
               chk("rdata", ed, s_axi_rdata);
               chk("rresp", er, s_axi_rresp);
               n = 99;
            end
         end
         if (n != 100) hang;
      end
   endtask
   // one host cycle, valid for a single edge, result one cycle later
   task hchk(input [31:0] a, input enp, input epf);
      begin
         @(posedge aclk);
         host_addr <= a;
         host_valid <= 1'b1;
         @(posedge aclk);
         host_valid <= 1'b0;
         #1;
         chk("np_fwd", enp, agp_np_fwd);
         chk("pf_fwd", epf, agp_pf_fwd);
      end
   endtask
   task t_reset;
      begin
         rd(32'h80, 32'hfff0, 2'h0);
         rd(32'h88, 32'h0, 2'h0);
         rd(32'h90, 32'hfff0, 2'h0);
         rd(32'h98, 32'h0, 2'h0);
         rd(32'hf8, 32'h0, 2'h0);
         hchk(32'hfff00000, 1'h0, 1'h0);
         $display("t_reset done");
      end
   endtask
   task t_fields;
      begin
         wr(32'h80, 32'hffff123f, 4'hf, 2'h0);
         rd(32'h80, 32'h1230, 2'h0);
         wr(32'hf8, 32'h0d, 4'h1, 2'h0);
         rd(32'hf8, 32'h0d, 2'h0);
         chk("bridge_ctrl", 32'h0d, {24'h0, bridge_ctrl});
         rd(32'h200, 32'h0, 2'h2);
         wr(32'h200, 32'h1, 4'hf, 2'h2);
         $display("t_fields done");
      end
   endtask
   task t_np;
      begin
         wr(32'h80, 32'h1230, 4'h3, 2'h0);
         wr(32'h88, 32'h1250, 4'h3, 2'h0);
         hchk(32'h122fffff, 1'h0, 1'h0);
         hchk(32'h12300000, 1'h1, 1'h0);
         hchk(32'h125fffff, 1'h1, 1'h0);
         hchk(32'h12600000, 1'h0, 1'h0);
         hchk(32'h02400000, 1'h0, 1'h0);
         wr(32'h100, 32'h12400000, 4'hf, 2'h0);
         rd(32'h100, 32'h12400000, 2'h0);
         rd(32'h104, 32'h1, 2'h0);
         $display("t_np done");
      end
   endtask
   task t_pf;
      begin
         wr(32'h90, 32'h8000, 4'h3, 2'h0);
         wr(32'h98, 32'h8000, 4'h3, 2'h0);
         hchk(32'h7fffffff, 1'h0, 1'h0);
         hchk(32'h80000000, 1'h0, 1'h1);
         hchk(32'h800fffff, 1'h0, 1'h1);
         hchk(32'h80100000, 1'h0, 1'h0);
         wr(32'h100, 32'h80080000, 4'hf, 2'h0);
         rd(32'h104, 32'h2, 2'h0);
         $display("t_pf done");
      end
   endtask
   task t_empty;
      begin
         wr(32'h90, 32'h9000, 4'h3, 2'h0);
         hchk(32'h80000000, 1'h0, 1'h0);
         chk("np_seen", 32'h2, np_seen);
         chk("pf_seen", 32'h2, pf_seen);
         $display("t_empty done");
      end
   endtask
   task t_rerun;
      begin
         @(posedge aclk);
         aresetn <= 1'b0;
         repeat (3) @(posedge aclk);
         aresetn <= 1'b1;
         chk("bridge_ctrl", 32'h0, {24'h0, bridge_ctrl});
         rd(32'h80, 32'hfff0, 2'h0);
         rd(32'h98, 32'h0, 2'h0);
         hchk(32'h12400000, 1'h0, 1'h0);
         $display("t_rerun done");
      end
   endtask
   initial begin
      mismatches = 0;
      checked = 0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, host_valid} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, host_addr} = 128'h0;
      {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_fields;
      t_np;
      t_pf;
      t_empty;
      t_rerun;
      report_and_stop;
   end
endmodule
